// ### rtl/sepc_defines.svh
// Constants for the serial EEPROM instruction and write-guard controller
`ifndef SEPC_DEFINES_SVH
`define SEPC_DEFINES_SVH
`define SEPC_WORDS 128
`define SEPC_HDR_LAST 5'h09
`define SEPC_DATA_LAST 5'h0f
`define SEPC_RD_LAST_WORD 4'hf
`define SEPC_RD_LAST_BND 4'h7
`define SEPC_OP_CTRL 2'h0
`define SEPC_OP_WRITE 2'h1
`define SEPC_OP_READ 2'h2
`define SEPC_OP_CLEAR 2'h3
`define SEPC_SUB_LOCK 2'h0
`define SEPC_SUB_FILL 2'h1
`define SEPC_SUB_WEN 2'h3
`define SEPC_BND_CLEARED 8'hff
`define SEPC_BND_FREEZE_ADDR 8'h00
`define SEPC_BND_RESET 8'hff
`define SEPC_WORD_ERASED 16'hffff
`define SEPC_T_WP_NS 10000000
`define SEPC_CLK_NS 8
`define SEPC_WP_CYCLES ((`SEPC_T_WP_NS + `SEPC_CLK_NS - 1) / `SEPC_CLK_NS)
`endif

// ### rtl/sepc_pkg.sv
// Types for the serial EEPROM instruction and write-guard controller
package sepc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_HDR = 3'b001,
        ST_DATA = 3'b010,
        ST_READ = 3'b011,
        ST_WAIT_CS = 3'b100
    } sepc_state_e;

    typedef enum logic [3:0] {
        CMD_NONE = 4'b0000,
        CMD_READ = 4'b0001,
        CMD_WEN = 4'b0010,
        CMD_WRITE = 4'b0011,
        CMD_FILL_ALL = 4'b0100,
        CMD_LOCK_WRITES = 4'b0101,
        CMD_BND_READ = 4'b0110,
        CMD_BND_UNLOCK = 4'b0111,
        CMD_BND_CLEAR = 4'b1000,
        CMD_BND_SET = 4'b1001,
        CMD_BND_FREEZE = 4'b1010
    } sepc_cmd_e;

    typedef struct packed {
        logic cs;
        logic serial_clock;
        logic serial_data_in;
        logic program_enable;
        logic pre;
    } sepc_pins_s;
endpackage

// ### rtl/sepc_top.sv
// Serial EEPROM instruction decoder, write guard and self-timed programming
`timescale 1ns/10ps
`include "sepc_defines.svh"

module sepc_top #(
    parameter int P_WP_CYCLES = `SEPC_WP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_chip_select,
    input wire logic i_serial_clock,
    input wire logic i_serial_data_in,
    input wire logic i_program_enable_pin,
    input wire logic i_protect_select_pin,
    output logic o_serial_data_out,
    output logic o_serial_data_out_oe_n
);
    localparam int TW = $clog2(P_WP_CYCLES + 1);

    if (P_WP_CYCLES < 1) begin : g_bad_wp
        $error("P_WP_CYCLES must be at least one");
    end

    sepc_pkg::sepc_pins_s pin_raw;
    sepc_pkg::sepc_pins_s pin_m;
    sepc_pkg::sepc_pins_s pin_s;
    sepc_pkg::sepc_pins_s pin_d;
    logic sclk_rise;
    logic cs_fall;

    assign pin_raw = '{cs: i_chip_select, serial_clock: i_serial_clock,
                       serial_data_in: i_serial_data_in,
                       program_enable: i_program_enable_pin, pre: i_protect_select_pin};

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pin_m <= '0;
            pin_s <= '0;
            pin_d <= '0;
        end else begin
            pin_m <= pin_raw;
            pin_s <= pin_m;
            pin_d <= pin_s;
        end
    end

    // The serial clock is slow against i_clk, so edges are found by sampling
    assign sclk_rise = pin_s.serial_clock & ~pin_d.serial_clock;
    assign cs_fall = ~pin_s.cs & pin_d.cs;

    sepc_pkg::sepc_state_e state, next_state;
    sepc_pkg::sepc_cmd_e cmd, next_cmd;
    sepc_pkg::sepc_cmd_e prog_cmd, next_prog_cmd;
    logic [4:0] bitcnt, next_bitcnt;
    logic [9:0] hdr, next_hdr;
    logic [15:0] data, next_data;
    logic wen, next_wen;
    logic armed, next_armed;
    logic [7:0] bnd, next_bnd;
    logic frozen, next_frozen;
    logic [TW-1:0] wp_timer, next_wp_timer;
    logic [6:0] prog_addr, next_prog_addr;
    logic [15:0] prog_data, next_prog_data;
    logic status_pending, next_status_pending;
    logic [15:0] rd_sr, next_rd_sr;
    logic [3:0] rd_cnt, next_rd_cnt;
    logic [6:0] rd_addr, next_rd_addr;
    logic next_sdo, next_sdo_oe_n;
    logic cmd_ok;
    logic start_prog;
    logic prog_done;
    logic [15:0] mem [0:`SEPC_WORDS-1];

    function automatic sepc_pkg::sepc_cmd_e decode(input logic [9:0] h, input logic pre);
        sepc_pkg::sepc_cmd_e c;
        c = sepc_pkg::CMD_NONE;
        // Protect-select picks the guard instruction set
        if (!pre) begin
            if (h[9:8] == `SEPC_OP_READ) begin
                c = sepc_pkg::CMD_READ;
            end else if (h[9:8] == `SEPC_OP_WRITE) begin
                c = sepc_pkg::CMD_WRITE;
            end else if (h[9:8] == `SEPC_OP_CTRL && h[7:6] == `SEPC_SUB_WEN) begin
                c = sepc_pkg::CMD_WEN;
            end else if (h[9:8] == `SEPC_OP_CTRL && h[7:6] == `SEPC_SUB_FILL) begin
                c = sepc_pkg::CMD_FILL_ALL;
            end else if (h[9:8] == `SEPC_OP_CTRL && h[7:6] == `SEPC_SUB_LOCK) begin
                c = sepc_pkg::CMD_LOCK_WRITES;
            end
        end else begin
            if (h[9:8] == `SEPC_OP_READ) begin
                c = sepc_pkg::CMD_BND_READ;
            end else if (h[9:8] == `SEPC_OP_CTRL && h[7:6] == `SEPC_SUB_WEN) begin
                c = sepc_pkg::CMD_BND_UNLOCK;
            end else if (h[9:8] == `SEPC_OP_CLEAR && h[7:0] == `SEPC_BND_CLEARED) begin
                c = sepc_pkg::CMD_BND_CLEAR;
            end else if (h[9:8] == `SEPC_OP_WRITE) begin
                c = sepc_pkg::CMD_BND_SET;
            end else if (h[9:8] == `SEPC_OP_CTRL && h[7:0] == `SEPC_BND_FREEZE_ADDR) begin
                c = sepc_pkg::CMD_BND_FREEZE;
            end
        end
        return c;
    endfunction

    // Validity is judged on the pins as they stand at the select fall
    always_comb begin
        case (cmd)
            sepc_pkg::CMD_WRITE:
                cmd_ok = wen && pin_s.program_enable && !pin_s.pre
                         && ({1'b0, prog_addr} < bnd);
            sepc_pkg::CMD_FILL_ALL:
                cmd_ok = wen && pin_s.program_enable && !pin_s.pre
                         && bnd == `SEPC_BND_CLEARED;
            sepc_pkg::CMD_BND_CLEAR:
                cmd_ok = armed && !frozen && pin_s.program_enable && pin_s.pre;
            sepc_pkg::CMD_BND_SET:
                cmd_ok = armed && !frozen && pin_s.program_enable && pin_s.pre
                         && bnd == `SEPC_BND_CLEARED;
            sepc_pkg::CMD_BND_FREEZE:
                cmd_ok = armed && !frozen && pin_s.program_enable && pin_s.pre;
            default:
                cmd_ok = 1'b0;
        endcase
    end

    // Select fall after the last bit launches the cycle
    assign start_prog = cs_fall && state == sepc_pkg::ST_WAIT_CS && cmd_ok;
    assign prog_done = wp_timer == TW'(1);

    always_comb begin
        next_state = state;
        next_cmd = cmd;
        next_prog_cmd = prog_cmd;
        next_bitcnt = bitcnt;
        next_hdr = hdr;
        next_data = data;
        next_wen = wen;
        next_armed = armed;
        next_bnd = bnd;
        next_frozen = frozen;
        next_wp_timer = wp_timer;
        next_prog_addr = prog_addr;
        next_prog_data = prog_data;
        next_status_pending = status_pending;
        next_rd_sr = rd_sr;
        next_rd_cnt = rd_cnt;
        next_rd_addr = rd_addr;
        next_sdo = o_serial_data_out;
        if (wp_timer != '0) begin
            next_wp_timer = wp_timer - TW'(1);
        end
        if (prog_done) begin
            case (prog_cmd)
                sepc_pkg::CMD_BND_CLEAR: next_bnd = `SEPC_BND_CLEARED;
                sepc_pkg::CMD_BND_SET: next_bnd = {1'b0, prog_addr};
                sepc_pkg::CMD_BND_FREEZE: next_frozen = 1'b1;
                default: next_bnd = bnd;
            endcase
        end
        if (cs_fall) begin
            next_state = sepc_pkg::ST_IDLE;
            // Status survives select toggles while busy
            if (wp_timer == '0) begin
                next_status_pending = 1'b0;
            end
            if (state != sepc_pkg::ST_IDLE) begin
                next_armed = 1'b0;
            end
            if (state == sepc_pkg::ST_WAIT_CS) begin
                if (cmd == sepc_pkg::CMD_WEN && pin_s.program_enable) begin
                    next_wen = 1'b1;
                end else if (cmd == sepc_pkg::CMD_LOCK_WRITES) begin
                    next_wen = 1'b0;
                end else if (cmd == sepc_pkg::CMD_BND_UNLOCK) begin
                    next_armed = wen && pin_s.program_enable && pin_s.pre;
                end
            end
            if (start_prog) begin
                next_wp_timer = TW'(P_WP_CYCLES);
                next_prog_cmd = cmd;
                next_status_pending = 1'b1;
            end
        end else if (pin_s.cs && sclk_rise) begin
            case (state)
                sepc_pkg::ST_IDLE: begin
                    // Busy device ignores start bits
                    if (pin_s.serial_data_in && wp_timer == '0) begin
                        next_state = sepc_pkg::ST_HDR;
                        next_bitcnt = '0;
                        next_status_pending = 1'b0;
                    end
                end
                sepc_pkg::ST_HDR: begin
                    next_hdr = {hdr[8:0], pin_s.serial_data_in};
                    next_bitcnt = bitcnt + 5'h01;
                    if (bitcnt == `SEPC_HDR_LAST) begin
                        next_cmd = decode(next_hdr, pin_s.pre);
                        next_prog_addr = next_hdr[6:0];
                        next_bitcnt = '0;
                        next_rd_cnt = '0;
                        next_rd_addr = next_hdr[6:0];
                        next_state = sepc_pkg::ST_WAIT_CS;
                        if (next_cmd == sepc_pkg::CMD_READ) begin
                            next_sdo = 1'b0;
                            next_rd_sr = mem[next_hdr[6:0]];
                            next_state = sepc_pkg::ST_READ;
                        end else if (next_cmd == sepc_pkg::CMD_BND_READ) begin
                            next_sdo = 1'b0;
                            next_rd_sr = {bnd, 8'h00};
                            next_state = sepc_pkg::ST_READ;
                        end else if (next_cmd == sepc_pkg::CMD_WRITE
                                     || next_cmd == sepc_pkg::CMD_FILL_ALL) begin
                            next_state = sepc_pkg::ST_DATA;
                        end
                    end
                end
                sepc_pkg::ST_DATA: begin
                    next_data = {data[14:0], pin_s.serial_data_in};
                    next_bitcnt = bitcnt + 5'h01;
                    if (bitcnt == `SEPC_DATA_LAST) begin
                        next_prog_data = next_data;
                        next_state = sepc_pkg::ST_WAIT_CS;
                    end
                end
                sepc_pkg::ST_READ: begin
                    next_sdo = rd_sr[15];
                    next_rd_sr = {rd_sr[14:0], 1'b0};
                    next_rd_cnt = rd_cnt + 4'h1;
                    if (cmd == sepc_pkg::CMD_READ && rd_cnt == `SEPC_RD_LAST_WORD) begin
                        // Sequential read wraps at the top word, no further dummy
                        next_rd_addr = rd_addr + 7'h01;
                        next_rd_sr = mem[rd_addr + 7'h01];
                    end else if (cmd == sepc_pkg::CMD_BND_READ
                                 && rd_cnt == `SEPC_RD_LAST_BND) begin
                        next_rd_cnt = rd_cnt;
                    end
                end
                default: next_state = state;
            endcase
        end
        if (next_state != sepc_pkg::ST_READ) begin
            next_sdo = next_wp_timer == '0;
        end
        next_sdo_oe_n = !(pin_s.cs
                          && (next_state == sepc_pkg::ST_READ || next_status_pending));
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= sepc_pkg::ST_IDLE;
            cmd <= sepc_pkg::CMD_NONE;
            prog_cmd <= sepc_pkg::CMD_NONE;
            bitcnt <= '0;
            hdr <= '0;
            data <= '0;
            wen <= 1'b0;
            armed <= 1'b0;
            bnd <= `SEPC_BND_RESET;
            frozen <= 1'b0;
            wp_timer <= '0;
            prog_addr <= '0;
            prog_data <= '0;
            status_pending <= 1'b0;
            rd_sr <= '0;
            rd_cnt <= '0;
            rd_addr <= '0;
            o_serial_data_out <= 1'b0;
            o_serial_data_out_oe_n <= 1'b1;
        end else begin
            state <= next_state;
            cmd <= next_cmd;
            prog_cmd <= next_prog_cmd;
            bitcnt <= next_bitcnt;
            hdr <= next_hdr;
            data <= next_data;
            wen <= next_wen;
            armed <= next_armed;
            bnd <= next_bnd;
            frozen <= next_frozen;
            wp_timer <= next_wp_timer;
            prog_addr <= next_prog_addr;
            prog_data <= next_prog_data;
            status_pending <= next_status_pending;
            rd_sr <= next_rd_sr;
            rd_cnt <= next_rd_cnt;
            rd_addr <= next_rd_addr;
            o_serial_data_out <= next_sdo;
            o_serial_data_out_oe_n <= next_sdo_oe_n;
        end
    end

    // Array is committed at the end of the self-timed cycle
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            for (int i = 0; i < `SEPC_WORDS; i++) begin
                mem[i] <= `SEPC_WORD_ERASED;
            end
        end else if (prog_done && prog_cmd == sepc_pkg::CMD_FILL_ALL) begin
            for (int i = 0; i < `SEPC_WORDS; i++) begin
                mem[i] <= prog_data;
            end
        end else if (prog_done && prog_cmd == sepc_pkg::CMD_WRITE) begin
            mem[prog_addr] <= prog_data;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    sequence s_hdr_end(sepc_pkg::sepc_cmd_e c);
        pin_s.cs && sclk_rise && state == sepc_pkg::ST_HDR && bitcnt == `SEPC_HDR_LAST
        && decode({hdr[8:0], pin_s.serial_data_in}, pin_s.pre) == c;
    endsequence

    sequence s_guard_first;
        pin_s.cs && sclk_rise && state == sepc_pkg::ST_READ
        && cmd == sepc_pkg::CMD_BND_READ && rd_cnt == '0;
    endsequence

    sequence s_commit(sepc_pkg::sepc_cmd_e c);
        cs_fall && state == sepc_pkg::ST_WAIT_CS && cmd == c;
    endsequence

    busy_blocks_start_a: assert property (
        (wp_timer > TW'(1) && state == sepc_pkg::ST_IDLE) |=> state == sepc_pkg::ST_IDLE)
        else $error("instruction accepted while busy");
    wp_length_a: assert property (
        start_prog |=> wp_timer == TW'(P_WP_CYCLES))
        else $error("programming time not loaded");
    sdo_float_a: assert property (
        !pin_s.cs |=> o_serial_data_out_oe_n)
        else $error("data-out driven while deselected");
    busy_status_a: assert property (
        (pin_s.cs && !cs_fall && status_pending && wp_timer > TW'(1)
         && state == sepc_pkg::ST_IDLE) |=> !o_serial_data_out_oe_n && !o_serial_data_out)
        else $error("busy not shown low");
    lock_writes_a: assert property (
        s_commit(sepc_pkg::CMD_LOCK_WRITES) |=> !wen)
        else $error("write enable kept after lock");
    invalid_idle_a: assert property (
        (cs_fall && state == sepc_pkg::ST_WAIT_CS && !cmd_ok && wp_timer == '0)
        |=> wp_timer == '0)
        else $error("invalid instruction started a cycle");
    unlock_gate_a: assert property (
        (s_commit(sepc_pkg::CMD_BND_UNLOCK) ##0 !(wen && pin_s.program_enable && pin_s.pre))
        |=> !armed)
        else $error("unlock armed without conditions");
    arm_drop_a: assert property (
        (cs_fall && state != sepc_pkg::ST_IDLE && cmd != sepc_pkg::CMD_BND_UNLOCK)
        |=> !armed)
        else $error("unlock flag survived another instruction");
    freeze_hold_a: assert property (
        frozen |=> frozen && $stable(bnd))
        else $error("frozen guard changed");
    guard_block_a: assert property (
        (s_commit(sepc_pkg::CMD_WRITE) ##0 ({1'b0, prog_addr} >= bnd)) |=> wp_timer == '0)
        else $error("write started inside guarded range");
    fill_gate_a: assert property (
        (s_commit(sepc_pkg::CMD_FILL_ALL)
         ##0 !(bnd == `SEPC_BND_CLEARED && wen && pin_s.program_enable && !pin_s.pre))
        |=> wp_timer == '0)
        else $error("fill-all started without conditions");
    guard_read_a: assert property (
        s_hdr_end(sepc_pkg::CMD_BND_READ) |=> !o_serial_data_out && !o_serial_data_out_oe_n)
        else $error("guard read dummy bit wrong");
    guard_first_a: assert property (
        s_guard_first |=> o_serial_data_out == bnd[7])
        else $error("guard read first bit wrong");
    read_open_a: assert property (
        s_hdr_end(sepc_pkg::CMD_READ) |=> state == sepc_pkg::ST_READ && !o_serial_data_out)
        else $error("array read refused");
endmodule

// ### dv/sepc_host.sv
// Host model that drives the serial instruction link and watches data-out
`timescale 1ns/10ps
module sepc_host (
    input wire logic i_sdo,
    input wire logic i_sdo_oe_n,
    output logic o_chip_select,
    output logic o_serial_clock,
    output logic o_serial_data_in,
    output logic o_program_enable_pin,
    output logic o_protect_select_pin
);
    logic sdo_line;

    // A floating data-out reads as the inverse, so a missing enable is caught
    assign sdo_line = i_sdo_oe_n ? ~i_sdo : i_sdo;

    // Serial clock rests low between frames
    initial begin
        o_chip_select = 1'b0;
        o_serial_clock = 1'b0;
        o_serial_data_in = 1'b1;
        o_program_enable_pin = 1'b0;
        o_protect_select_pin = 1'b0;
    end

    // Pin levels are set before select and held for the whole frame
    task automatic start(input logic prog_en, input logic pre);
        o_program_enable_pin = prog_en;
        o_protect_select_pin = pre;
        o_chip_select = 1'b1;
        #40;
    endtask

    task automatic bit_out(input logic b);
        o_serial_data_in = b;
        #40 o_serial_clock = 1'b1;
        #40 o_serial_clock = 1'b0;
    endtask

    task automatic send11(input logic [10:0] h);
        for (int i = 10; i >= 0; i--) begin
            bit_out(h[i]);
        end
    endtask

    task automatic send16(input logic [15:0] d);
        for (int i = 15; i >= 0; i--) begin
            bit_out(d[i]);
        end
    endtask

    // Sampled just before the next rise, where the previous bit has settled
    task automatic read_bits(output logic [16:0] v, input int n);
        v = '0;
        for (int i = 0; i < n; i++) begin
            o_serial_data_in = 1'b0;
            #32 v = {v[15:0], sdo_line};
            #8 o_serial_clock = 1'b1;
            #40 o_serial_clock = 1'b0;
        end
    endtask

    // Select drops before any further rise; data line is left toggled
    task automatic finish();
        #8 o_chip_select = 1'b0;
        o_serial_data_in = ~o_serial_data_in;
        #80;
    endtask

    // No new instruction until ready is seen; select toggles between looks
    task automatic poll(output int busy, output logic shown, output logic ready);
        busy = 0;
        shown = 1'b1;
        ready = 1'b0;
        for (int i = 0; i < 40 && !ready && shown; i++) begin
            o_chip_select = 1'b1;
            #48;
            shown = (i_sdo_oe_n === 1'b0);
            ready = shown && (i_sdo === 1'b1);
            if (shown && !ready) begin
                busy++;
            end
            o_chip_select = 1'b0;
            #40;
        end
    endtask

    // Holds select until ready, then clocks a lone start bit
    task automatic clear_ready(output logic ready, output logic oe_after);
        ready = 1'b0;
        o_chip_select = 1'b1;
        for (int i = 0; i < 200 && !ready; i++) begin
            #8;
            ready = (i_sdo_oe_n === 1'b0) && (i_sdo === 1'b1);
        end
        bit_out(1'b1);
        #40 oe_after = i_sdo_oe_n;
        o_chip_select = 1'b0;
        #80;
    endtask
endmodule

// ### dv/sepc_top_test.sv
// Self-checking bench for the serial EEPROM instruction controller
`timescale 1ns/10ps
module sepc_top_test;
    // Flags: wide, program enable, pre, status mode (0 none, 1 busy, 2 skip, 3 wait), read kind
    typedef struct packed {
        logic [26:0] bits;
        logic [6:0] f;
        logic [15:0] exp;
    } sepc_row_s;

    logic i_clk, i_reset, cs, ser_clk, ser_din, prog_en, pre, sdo, sdo_oe_n, rdy, oe_after;
    logic [16:0] v;
    int error_cnt = 0;
    int total_checks = 0;
    sepc_row_s rows[$];

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end

    sepc_top #(.P_WP_CYCLES(50)) u_sepc_top (
        .i_clk(i_clk), .i_reset(i_reset), .i_chip_select(cs), .i_serial_clock(ser_clk),
        .i_serial_data_in(ser_din), .i_program_enable_pin(prog_en), .i_protect_select_pin(pre),
        .o_serial_data_out(sdo), .o_serial_data_out_oe_n(sdo_oe_n));
    sepc_host u_sepc_host (
        .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n), .o_chip_select(cs), .o_serial_clock(ser_clk),
        .o_serial_data_in(ser_din), .o_program_enable_pin(prog_en),
        .o_protect_select_pin(pre));

    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("Error at %0t ns: %s", $time, what);
        end
    endtask

    task automatic close_out();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    function automatic sepc_row_s r(input logic [1:0] op, input logic [7:0] a,
            input logic [15:0] d, input logic [6:0] f, input logic [15:0] exp);
        return '{{1'b1, op, a, d}, f, exp};
    endfunction

    task automatic run_row(input sepc_row_s w);
        int busy;
        logic shown, ready;
        @(posedge i_clk) #1;
        u_sepc_host.start(w.f[5], w.f[4]);
        u_sepc_host.send11(w.bits[26:16]);
        if (w.f[6]) u_sepc_host.send16(w.bits[15:0]);
        if (w.f[1:0] == 2'd1) u_sepc_host.read_bits(v, 17);
        if (w.f[1:0] == 2'd2) u_sepc_host.read_bits(v, 9);
        u_sepc_host.finish();
        if (w.f[1:0] == 2'd1) check(v === {1'b0, w.exp}, "word read mismatch");
        if (w.f[1:0] == 2'd2) check(v[8:0] === {1'b0, w.exp[7:0]}, "guard read mismatch");
        if (w.f[3:2] < 2'd2) u_sepc_host.poll(busy, shown, ready);
        if (w.f[3:2] == 2'd0) check(shown === 1'b0, "status shown after refused frame");
        if (w.f[3:2] == 2'd1) check(ready === 1'b1 && busy >= 3, "busy period wrong");
        if (w.f[3:2] == 2'd3) repeat (100) @(posedge i_clk);
    endtask

    initial begin
        #400000;
        error_cnt++;
        close_out();
    end

    initial begin
        i_reset = 1'b1;
        repeat (5) @(posedge i_clk);
        check(sdo_oe_n === 1'b1, "data-out driven in reset");
        #1 i_reset = 1'b0;
        repeat (5) @(posedge i_clk);
        rows.push_back(r(2'h2, 8'h00, 16'h0000, 7'b0_0_1_10_10, 16'h00ff));
        rows.push_back(r(2'h0, 8'h40, 16'h1234, 7'b1_1_0_00_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h05, 16'h0000, 7'b0_0_0_10_01, 16'hffff));
        rows.push_back(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_0_10_00, 16'h0000));
        rows.push_back(r(2'h0, 8'h40, 16'h1234, 7'b1_1_0_01_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h00, 16'h0000, 7'b0_0_0_10_01, 16'h1234));
        rows.push_back(r(2'h2, 8'h7f, 16'h0000, 7'b0_0_0_10_01, 16'h1234));
        rows.push_back(r(2'h0, 8'h40, 16'h9999, 7'b1_0_0_00_00, 16'h0000));
        rows.push_back(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_1_10_00, 16'h0000));
        rows.push_back(r(2'h1, 8'h10, 16'h0000, 7'b0_1_1_01_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h00, 16'h0000, 7'b0_0_1_10_10, 16'h0010));
        rows.push_back(r(2'h1, 8'h0f, 16'ha5a5, 7'b1_1_0_01_00, 16'h0000));
        rows.push_back(r(2'h1, 8'h10, 16'h5a5a, 7'b1_1_0_00_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h0f, 16'h0000, 7'b0_0_0_10_01, 16'ha5a5));
        rows.push_back(r(2'h2, 8'h10, 16'h0000, 7'b0_0_0_10_01, 16'h1234));
        rows.push_back(r(2'h0, 8'h40, 16'h7777, 7'b1_1_0_00_00, 16'h0000));
        rows.push_back(r(2'h3, 8'hff, 16'h0000, 7'b0_1_1_00_00, 16'h0000));
        rows.push_back(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_1_10_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h10, 16'h0000, 7'b0_0_0_10_01, 16'h1234));
        rows.push_back(r(2'h3, 8'hff, 16'h0000, 7'b0_1_1_00_00, 16'h0000));
        rows.push_back(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_1_10_00, 16'h0000));
        rows.push_back(r(2'h3, 8'hff, 16'h0000, 7'b0_1_1_01_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h00, 16'h0000, 7'b0_0_1_10_10, 16'h00ff));
        rows.push_back(r(2'h1, 8'h7f, 16'h0bad, 7'b1_1_0_01_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h7f, 16'h0000, 7'b0_0_0_10_01, 16'h0bad));
        rows.push_back(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_1_10_00, 16'h0000));
        rows.push_back(r(2'h1, 8'h85, 16'h0000, 7'b0_1_1_01_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h00, 16'h0000, 7'b0_0_1_10_10, 16'h0005));
        rows.push_back(r(2'h0, 8'h3f, 16'h0000, 7'b0_0_0_10_00, 16'h0000));
        rows.push_back(r(2'h1, 8'h00, 16'h4444, 7'b1_1_0_00_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h00, 16'h0000, 7'b0_0_0_10_01, 16'h1234));
        rows.push_back(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_1_10_00, 16'h0000));
        rows.push_back(r(2'h3, 8'hff, 16'h0000, 7'b0_1_1_00_00, 16'h0000));
        rows.push_back(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_0_10_00, 16'h0000));
        rows.push_back(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_1_10_00, 16'h0000));
        rows.push_back(r(2'h0, 8'h00, 16'h0000, 7'b0_1_1_01_00, 16'h0000));
        rows.push_back(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_1_10_00, 16'h0000));
        rows.push_back(r(2'h3, 8'hff, 16'h0000, 7'b0_1_1_11_00, 16'h0000));
        rows.push_back(r(2'h2, 8'h00, 16'h0000, 7'b0_0_1_10_10, 16'h0005));
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // Start bits during a busy cycle must not open a frame
        run_row(r(2'h0, 8'hc0, 16'h0000, 7'b0_1_0_10_00, 16'h0000));
        @(posedge i_clk) #1;
        u_sepc_host.start(1'b1, 1'b0);
        u_sepc_host.send11({1'b1, 2'h1, 8'h01});
        u_sepc_host.send16(16'h1111);
        u_sepc_host.finish();
        u_sepc_host.start(1'b0, 1'b1);
        u_sepc_host.bit_out(1'b1);
        u_sepc_host.bit_out(1'b1);
        u_sepc_host.read_bits(v, 1);
        check(v[0] === 1'b0 && sdo_oe_n === 1'b0, "frame taken while busy");
        u_sepc_host.finish();
        u_sepc_host.clear_ready(rdy, oe_after);
        check(rdy === 1'b1 && oe_after === 1'b1, "ready not cleared by start bit");
        run_row(r(2'h2, 8'h01, 16'h0000, 7'b0_0_0_10_01, 16'h1111));
        close_out();
    end
endmodule
